// ### verilog/sensor_link_pkg.sv
// shared constants and state types for both ends of the sensor serial link
package sensor_link_pkg;
    // system clock
    localparam int CLK_NS         = 40;
    // serial clock half period, 1 MHz at most
    localparam int HALF_NS        = 500;
    localparam int HALF_CYC       = (HALF_NS + CLK_NS - 1) / CLK_NS;
    // host side least times
    localparam int NCS_SCLK_NS    = 120;
    localparam int NCS_SCLK_CYC   = (NCS_SCLK_NS + CLK_NS - 1) / CLK_NS;
    localparam int HOLD_RD_NS     = 120;
    localparam int HOLD_RD_CYC    = (HOLD_RD_NS + CLK_NS - 1) / CLK_NS;
    localparam int HOLD_WR_US     = 20;
    localparam int HOLD_WR_CYC    = (HOLD_WR_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int SWW_US         = 30;
    localparam int SWW_CYC        = (SWW_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int SWR_US         = 20;
    localparam int SWR_CYC        = (SWR_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int SRR_NS         = 500;
    localparam int SRR_CYC        = (SRR_NS + CLK_NS - 1) / CLK_NS;
    localparam int SRAD_US        = 4;
    localparam int SRAD_CYC       = (SRAD_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int BEXIT_NS       = 500;
    localparam int BEXIT_CYC      = (BEXIT_NS + CLK_NS - 1) / CLK_NS;
    // device side times
    localparam int MOT_RST_MS     = 23;
    localparam int MOT_RST_CYC    = MOT_RST_MS * 1000000 / CLK_NS;
    localparam int WAKE_S         = 1;
    localparam int WAKE_CYC       = WAKE_S * 1000000000 / CLK_NS;
    // counter widths
    localparam int HCNT_W         = 10;
    localparam int DCNT_W         = 25;
    // register addresses inside the device
    localparam logic [6:0] ADDR_STATUS = 7'h00;
    localparam logic [6:0] ADDR_MOTION = 7'h01;
    localparam logic [6:0] ADDR_REST   = 7'h02;
    localparam logic [6:0] ADDR_REINIT = 7'h03;
    // fields
    localparam logic       DIR_WRITE   = 1'b1;
    localparam int         REST_LSB    = 0;
    localparam int         REST_W      = 2;
    localparam logic [7:0] REST_RESET  = 8'h00;
    localparam int         VALID_BIT   = 0;
    localparam int         LOWPWR_BIT  = 1;
    localparam logic [7:0] REINIT_DATA = 8'h5A;

    typedef enum logic [4:0] {
        S_INIT = 5'h01,
        S_RUN  = 5'h02,
        S_REST = 5'h04,
        S_SHUT = 5'h08,
        S_WAKE = 5'h10
    } dev_state_t;

    typedef enum logic [5:0] {
        H_IDLE = 6'h01,
        H_LEAD = 6'h02,
        H_ADDR = 6'h04,
        H_GAP  = 6'h08,
        H_DATA = 6'h10,
        H_TAIL = 6'h20
    } host_state_t;
endpackage

// ### verilog/sensor_link_if.sv
// four-wire serial link plus shutdown pin between host and sensor
`timescale 1ns/100ps
interface sensor_link_if;
    logic sclk;
    logic mosi;
    logic ncs_n;
    logic shutdown;
    logic miso_out;
    logic miso_oe;
    logic miso;

    // undriven data line reads high
    assign miso = miso_oe ? miso_out : 1'b1;

    modport host (output sclk, output mosi, output ncs_n, output shutdown, input miso);
    modport device (input sclk, input mosi, input ncs_n, input shutdown, output miso_out, output miso_oe);
endinterface

// ### verilog/sensor_link_device.sv
// sensor end: serial slave port and power state timing
`timescale 1ns/100ps
module sensor_link_device #(
    parameter int MOT_RST_LIM = sensor_link_pkg::MOT_RST_CYC,
    parameter int WAKE_LIM    = sensor_link_pkg::WAKE_CYC
) (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       sys_rst,
    // link
    sensor_link_if.device   link,
    // user side
    input  wire logic [7:0] motion_data,
    output logic            motion_valid,
    output logic            low_current
);
    import sensor_link_pkg::*;

    logic              sclk_m, sclk_q, sclk_d, mosi_m, mosi_q, ncs_m, ncs_q, shut_m, shut_q;
    logic              rise, fall;
    logic [4:0]        bit_cnt;
    logic [7:0]        rx, tx, addr_reg, rest_reg;
    logic              is_read, wr_stb, reinit, reinit_seen;
    logic [7:0]        wr_data;
    dev_state_t        state;
    logic [DCNT_W-1:0] cnt;

    function automatic logic [7:0] read_value(input logic [6:0] a);
        case (a)
            ADDR_STATUS: read_value = {6'h00, low_current, motion_valid};
            ADDR_MOTION: read_value = motion_data;
            ADDR_REST:   read_value = rest_reg;
            default:     read_value = 8'h00;
        endcase
    endfunction

    // pin synchronisers; edges come from the second and third stages only
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            {sclk_m, sclk_q, sclk_d} <= 3'h7;
            {ncs_m, ncs_q} <= 2'h3;
            {mosi_m, mosi_q, shut_m, shut_q} <= 4'h0;
        end else begin
            {sclk_q, sclk_m} <= {sclk_m, link.sclk};
            sclk_d <= sclk_q;
            {mosi_q, mosi_m} <= {mosi_m, link.mosi};
            {ncs_q, ncs_m} <= {ncs_m, link.ncs_n};
            {shut_q, shut_m} <= {shut_m, link.shutdown};
        end
    end

    assign rise = sclk_q & ~sclk_d;
    assign fall = ~sclk_q & sclk_d;

    // receive shifter; select high aborts and restarts the port
    always_ff @(posedge clock) begin
        wr_stb <= 1'b0;
        if (sys_rst || ncs_q) begin
            bit_cnt  <= 5'h00;
            is_read  <= 1'b0;
            rx       <= 8'h00;
            addr_reg <= 8'h00;
            wr_data  <= 8'h00;
        end else if (rise && bit_cnt != 5'h10) begin
            rx      <= {rx[6:0], mosi_q};
            bit_cnt <= bit_cnt + 5'h01;
            if (bit_cnt == 5'h07) begin
                addr_reg <= {1'b0, rx[5:0], mosi_q};
                is_read  <= rx[6] != DIR_WRITE;
            end
            if (bit_cnt == 5'h0F && !is_read) begin
                wr_stb  <= 1'b1;
                wr_data <= {rx[6:0], mosi_q};
            end
        end
    end

    // transmit: load at end of address, shift on falling edges; release on select high
    always_ff @(posedge clock) begin
        if (sys_rst || ncs_q) begin
            link.miso_oe <= 1'b0;
            tx           <= 8'h00;
            // the data bit is left alone on deselect so it never moves inside the host's hold window
            if (sys_rst) begin
                link.miso_out <= 1'b1;
            end
        end else if (rise && bit_cnt == 5'h07 && rx[6] != DIR_WRITE) begin
            tx <= read_value({rx[5:0], mosi_q});
        end else if (fall && is_read && bit_cnt >= 5'h08 && bit_cnt < 5'h10) begin
            link.miso_out <= tx[7];
            link.miso_oe  <= 1'b1;
            tx            <= {tx[6:0], 1'b0};
        end
    end

    // register writes
    assign reinit = wr_stb && addr_reg[6:0] == ADDR_REINIT && wr_data == REINIT_DATA;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rest_reg <= REST_RESET;
        end else if (wr_stb && addr_reg[6:0] == ADDR_REST) begin
            rest_reg <= wr_data;
        end
    end

    // power states; shutdown overrides everything
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state       <= S_INIT;
            cnt         <= '0;
            reinit_seen <= 1'b0;
        end else if (shut_q && state != S_SHUT) begin
            state <= S_SHUT;
        end else begin
            case (state)
                S_INIT: begin
                    cnt <= reinit ? '0 : cnt + 1'b1;
                    if (!reinit && cnt >= DCNT_W'(MOT_RST_LIM - 1)) begin
                        state <= S_RUN;
                    end
                end
                S_RUN: begin
                    if (reinit) begin
                        state <= S_INIT;
                        cnt   <= '0;
                    end else if (rest_reg[REST_LSB +: REST_W] != '0) begin
                        state <= S_REST;
                    end
                end
                S_REST: begin
                    if (reinit) begin
                        state <= S_INIT;
                        cnt   <= '0;
                    end else if (rest_reg[REST_LSB +: REST_W] == '0) begin
                        state <= S_RUN;
                    end
                end
                S_SHUT: begin
                    if (!shut_q) begin
                        state       <= S_WAKE;
                        cnt         <= '0;
                        reinit_seen <= 1'b0;
                    end
                end
                S_WAKE: begin
                    // a reset written during wake-up is remembered, not lost
                    if (reinit) begin
                        reinit_seen <= 1'b1;
                    end
                    if (cnt != DCNT_W'(WAKE_LIM - 1)) begin
                        cnt <= cnt + 1'b1;
                    end else if (reinit_seen || reinit) begin
                        state <= S_INIT;
                        cnt   <= '0;
                    end
                end
                default: begin
                    state <= S_INIT;
                    cnt   <= '0;
                end
            endcase
        end
    end

    // user flags from state
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            motion_valid <= 1'b0;
            low_current  <= 1'b0;
        end else begin
            motion_valid <= state == S_RUN;
            low_current  <= state == S_SHUT || state == S_REST;
        end
    end
endmodule

// ### verilog/sensor_link_host.sv
// host end: serial master with transaction spacing and shutdown recovery
`timescale 1ns/100ps
module sensor_link_host (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       sys_rst,
    // link
    sensor_link_if.host     link,
    // request
    input  wire logic       req_valid,
    input  wire logic       req_write,
    input  wire logic [6:0] req_addr,
    input  wire logic [7:0] req_wdata,
    output logic            req_ready,
    // response
    output logic            rsp_valid,
    output logic [7:0]      rsp_rdata,
    // power control
    input  wire logic       shut_req
);
    import sensor_link_pkg::*;

    host_state_t       state;
    logic [HCNT_W-1:0] cnt, since, hi_cnt;
    logic [4:0]        div;
    logic [2:0]        bit_cnt;
    logic [7:0]        sh, rx, wdata_hold;
    logic              is_wr, own_cmd, last_write, need_reset, shut_d;
    logic              miso_m, miso_q;
    logic              tick, last_rise, tail_done, can_go, cur_wr;

    // least spacing from the previous data byte's last rise to a new start
    function automatic logic [HCNT_W-1:0] gap_needed(input logic prev_wr, input logic next_wr);
        if (prev_wr) begin
            gap_needed = next_wr ? HCNT_W'(SWW_CYC) : HCNT_W'(SWR_CYC);
        end else begin
            gap_needed = HCNT_W'(SRR_CYC);
        end
    endfunction

    // data-in pin synchroniser
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            {miso_m, miso_q} <= 2'h3;
        end else begin
            {miso_q, miso_m} <= {miso_m, link.miso};
        end
    end

    assign tick      = div == 5'(HALF_CYC - 1);
    assign last_rise = state == H_DATA && tick && !link.sclk && bit_cnt == 3'h7;
    assign tail_done = state == H_TAIL && cnt >= (is_wr ? HCNT_W'(HOLD_WR_CYC - 1) : HCNT_W'(HOLD_RD_CYC - 1));
    assign cur_wr    = need_reset | req_write;
    assign can_go    = state == H_IDLE && !link.shutdown && hi_cnt >= HCNT_W'(BEXIT_CYC)
                       && since >= gap_needed(last_write, cur_wr);
    assign req_ready = can_go && !need_reset;

    // serial clock divider; restarted on every shifting phase
    always_ff @(posedge clock) begin
        if (sys_rst || !(state == H_ADDR || state == H_DATA) || tick) begin
            div <= 5'h00;
        end else begin
            div <= div + 5'h01;
        end
    end

    // transaction sequencer and link drivers
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state      <= H_IDLE;
            cnt        <= '0;
            bit_cnt    <= 3'h0;
            sh         <= 8'h00;
            rx         <= 8'h00;
            wdata_hold <= 8'h00;
            is_wr      <= 1'b0;
            own_cmd    <= 1'b0;
            link.sclk  <= 1'b1;
            link.mosi  <= 1'b1;
            link.ncs_n <= 1'b1;
        end else begin
            case (state)
                H_IDLE: begin
                    if (can_go && (need_reset || req_valid)) begin
                        own_cmd    <= need_reset;
                        is_wr      <= cur_wr;
                        sh         <= need_reset ? {DIR_WRITE, ADDR_REINIT} : {req_write, req_addr};
                        wdata_hold <= need_reset ? REINIT_DATA : req_wdata;
                        link.ncs_n <= 1'b0;
                        cnt        <= '0;
                        state      <= H_LEAD;
                    end
                end
                H_LEAD: begin
                    cnt <= cnt + 1'b1;
                    if (cnt >= HCNT_W'(NCS_SCLK_CYC - 1)) begin
                        bit_cnt <= 3'h0;
                        state   <= H_ADDR;
                    end
                end
                H_ADDR, H_DATA: begin
                    if (tick && link.sclk) begin
                        link.sclk <= 1'b0;
                        link.mosi <= sh[7];
                        sh        <= {sh[6:0], 1'b1};
                    end else if (tick) begin
                        link.sclk <= 1'b1;
                        bit_cnt   <= bit_cnt + 3'h1;
                        if (state == H_DATA) begin
                            rx <= {rx[6:0], miso_q};
                        end
                        if (bit_cnt == 3'h7 && state == H_ADDR) begin
                            cnt   <= '0;
                            sh    <= wdata_hold;
                            state <= is_wr ? H_DATA : H_GAP;
                        end else if (bit_cnt == 3'h7) begin
                            cnt   <= '0;
                            state <= H_TAIL;
                        end
                    end
                end
                H_GAP: begin
                    // address-to-data delay before the first data fall
                    cnt <= cnt + 1'b1;
                    if (cnt >= HCNT_W'(SRAD_CYC - 1)) begin
                        bit_cnt <= 3'h0;
                        state   <= H_DATA;
                    end
                end
                H_TAIL: begin
                    cnt <= cnt + 1'b1;
                    if (tail_done) begin
                        link.ncs_n <= 1'b1;
                        state      <= H_IDLE; // data in keeps its last bit, a 3-cycle read tail is inside its hold
                    end
                end
                default: begin
                    state      <= H_IDLE;
                    link.ncs_n <= 1'b1;
                    link.sclk  <= 1'b1;
                end
            endcase
        end
    end

    // spacing timers, saturating; start open after reset
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            since      <= '1;
            hi_cnt     <= '1;
            last_write <= 1'b0;
        end else begin
            if (last_rise) begin
                since      <= '0;
                last_write <= is_wr;
            end else if (since != '1) begin
                since <= since + 1'b1;
            end
            if (!link.ncs_n) begin
                hi_cnt <= '0;
            end else if (hi_cnt != '1) begin
                hi_cnt <= hi_cnt + 1'b1;
            end
        end
    end

    // shutdown pin and the reset owed after it; a new fall wins over the clear
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            link.shutdown <= 1'b0;
            shut_d        <= 1'b0;
            need_reset    <= 1'b0;
        end else begin
            link.shutdown <= shut_req;
            shut_d        <= link.shutdown;
            if (shut_d && !link.shutdown) begin
                need_reset <= 1'b1;
            end else if (state == H_IDLE && can_go && need_reset) begin
                need_reset <= 1'b0;
            end
        end
    end

    // user response; internal reset writes give none
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rsp_valid <= 1'b0;
            rsp_rdata <= 8'h00;
        end else begin
            rsp_valid <= tail_done && !own_cmd;
            if (tail_done && !is_wr) begin
                rsp_rdata <= rx;
            end
        end
    end
endmodule

// ### tb/sensor_link_monitor.sv
// concurrent checks on the serial link joining host and sensor
`timescale 1ns/100ps
module sensor_link_monitor (
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // link
    input wire logic sclk,
    input wire logic mosi,
    input wire logic ncs_n,
    input wire logic shutdown,
    input wire logic miso_out,
    input wire logic miso_oe,
    input wire logic miso
);
    import sensor_link_pkg::*;

    logic [4:0] rise_cnt;   // serial clock rises in the current frame
    logic       dir;        // direction bit of the current frame
    logic       last_wr;    // previous complete frame was a write
    logic [9:0] hi_cnt;     // cycles the serial clock has stayed high
    logic [9:0] gap_cnt;    // cycles since the last data bit rise, saturating

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    // frame bit counter, cleared whenever select is inactive
    always_ff @(posedge clock) begin
        if (sys_rst || ncs_n) begin
            rise_cnt <= 5'h00;
        end else if ($rose(sclk)) begin
            rise_cnt <= rise_cnt + 5'h01;
        end
    end

    // direction of this frame and of the last full one
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            dir     <= 1'b0;
            last_wr <= 1'b0;
        end else if ($rose(sclk) && rise_cnt == 5'h00) begin
            dir <= mosi;
        end else if ($rose(sclk) && rise_cnt == 5'h0F) begin
            last_wr <= dir;
        end
    end

    // high time and spacing counters saturate so long idles never wrap
    always_ff @(posedge clock) begin
        if (sys_rst || !sclk) begin
            hi_cnt <= 10'h000;
        end else if (hi_cnt != 10'h3FF) begin
            hi_cnt <= hi_cnt + 10'h001;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            gap_cnt <= 10'h3FF;
        end else if ($rose(sclk) && rise_cnt == 5'h0F) begin
            gap_cnt <= 10'h000;
        end else if (gap_cnt != 10'h3FF) begin
            gap_cnt <= gap_cnt + 10'h001;
        end
    end

    sequence idle_gap;
        ncs_n [*8] ##1 ncs_n [*5];
    endsequence

    sequence mosi_hold;
        $stable(mosi) [*5];
    endsequence

    chk_miso_release: assert property ($rose(ncs_n) |-> ##[0:12] (!miso_oe && miso))
        else $error("data out not released after deselect");
    chk_deselect_gap: assert property ($rose(ncs_n) |-> idle_gap)
        else $error("select inactive time too short");
    chk_select_lead: assert property ($fell(ncs_n) |-> sclk [*3])
        else $error("serial clock moved too soon after select");
    chk_clock_half: assert property ($changed(sclk) |=> $stable(sclk) [*8] ##1 $stable(sclk) [*4])
        else $error("serial clock half period too short");
    chk_mosi_setup: assert property ($rose(sclk) |-> (mosi == $past(mosi, 3)) ##1 mosi_hold)
        else $error("data in not stable around rise");
    chk_miso_hold: assert property ($rose(sclk) && miso_oe |=> $stable(miso_out) [*8])
        else $error("data out changed while clock high");
    chk_write_spacing: assert property (
        $rose(sclk) && rise_cnt == 5'h0F && dir && last_wr |-> gap_cnt >= SWW_CYC - 1)
        else $error("write to write spacing too short");
    chk_wr_rd_spacing: assert property (
        $rose(sclk) && rise_cnt == 5'h07 && !dir && last_wr |-> gap_cnt >= SWR_CYC - 1)
        else $error("write to read spacing too short");
    chk_read_spacing: assert property (
        $fell(sclk) && rise_cnt == 5'h00 && !last_wr |-> gap_cnt >= SRR_CYC - 1)
        else $error("read to next command spacing too short");
    chk_addr_data_gap: assert property ($fell(sclk) && rise_cnt == 5'h08 && !dir |-> hi_cnt >= SRAD_CYC)
        else $error("address to data delay too short");
    chk_read_hold: assert property ($rose(ncs_n) && rise_cnt == 5'h10 && !dir |-> hi_cnt >= HOLD_RD_CYC)
        else $error("read select released too early");
    chk_write_hold: assert property ($rose(ncs_n) && rise_cnt == 5'h10 && dir |-> hi_cnt >= HOLD_WR_CYC)
        else $error("write select released too early");
    chk_wake_reinit: assert property ($fell(shutdown) |-> ##[1:20] $fell(ncs_n))
        else $error("no reset command after shutdown");
endmodule

// ### tb/motion_sensor_serial_port_timing_tb.sv
// self-checking bench: host and sensor joined, plus a bench-driven second link
`timescale 1ns/100ps
module motion_sensor_serial_port_timing_tb;
    import sensor_link_pkg::*;
    localparam int MRL  = 50;   // shortened motion delay after reinit
    localparam int WKL  = 100;  // shortened wake time
    localparam int HALF = 160;  // bench link clock half period in ns
    logic       clock;
    logic       sys_rst;
    logic       req_valid;
    logic       req_write;
    logic [6:0] req_addr;
    logic [7:0] req_wdata;
    logic       req_ready;
    logic       rsp_valid;
    logic [7:0] rsp_rdata;
    logic       shut_req;
    logic [7:0] motion_data;
    logic       motion_valid;
    logic       low_current;
    logic       motion_valid2;
    logic       low_current2;
    logic [7:0] rd;
    int         n_errors;
    int         num_checks;
    int         cnt;

    sensor_link_if link ();
    sensor_link_if link2 ();

    sensor_link_host sensor_link_host_inst (.clock(clock), .sys_rst(sys_rst), .link(link.host),
        .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .shut_req(shut_req));
    sensor_link_device #(.MOT_RST_LIM(MRL), .WAKE_LIM(WKL)) sensor_link_device_inst (.clock(clock),
        .sys_rst(sys_rst), .link(link.device), .motion_data(motion_data), .motion_valid(motion_valid),
        .low_current(low_current));
    // second sensor faces the bench, which may break the host's rules on purpose
    sensor_link_device #(.MOT_RST_LIM(MRL), .WAKE_LIM(WKL)) sensor_link_device_inst2 (.clock(clock),
        .sys_rst(sys_rst), .link(link2.device), .motion_data(motion_data), .motion_valid(motion_valid2),
        .low_current(low_current2));
    sensor_link_monitor sensor_link_monitor_inst (.clock(clock), .sys_rst(sys_rst), .sclk(link.sclk),
        .mosi(link.mosi), .ncs_n(link.ncs_n), .shutdown(link.shutdown), .miso_out(link.miso_out),
        .miso_oe(link.miso_oe), .miso(link.miso));

    // compare and count
    task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // bounded wait at falling edges, a run-out counts as a mismatch
    task automatic wait_high(ref logic sig, input int lim, output int took);
        took = 0;
        while (sig !== 1'b1 && took < lim) begin
            @(negedge clock);
            took++;
        end
        check8({7'h00, sig}, 8'h01, "bounded wait");
    endtask

    // one host request, held until taken, then wait for its response pulse
    task automatic xfer(input logic wr, input logic [6:0] addr, input logic [7:0] wdata,
                        output logic [7:0] rdata);
        int took;
        @(posedge clock);
        req_valid <= 1'b1;
        req_write <= wr;
        req_addr  <= addr;
        req_wdata <= wdata;
        @(negedge clock);
        wait_high(req_ready, 2000, took);
        @(posedge clock);
        req_valid <= 1'b0;
        @(negedge clock);
        wait_high(rsp_valid, 3000, took);
        rdata = rsp_rdata;
    endtask

    // bench-made serial bits on the second link, data out taken before the next fall; called on a rising edge
    task automatic bang(input logic [7:0] val, input int nbits, output logic [7:0] got);
        got = 8'h00;
        for (int i = 7; i > 7 - nbits; i--) begin
            link2.sclk <= 1'b0;
            link2.mosi <= val[i];
            repeat (HALF / CLK_NS) @(posedge clock);
            link2.sclk <= 1'b1;
            repeat (HALF / CLK_NS) @(posedge clock);
            got[i] = link2.miso;
        end
    endtask

    task automatic complete_run();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        clock = 1'b0;
        forever #(CLK_NS / 2) clock = ~clock;
    end

    // watchdog sized well above the roughly 8k cycles the sequence needs
    initial begin
        #(60000 * CLK_NS);
        n_errors++;
        $display("unexpected at %0t: run did not finish", $time);
        complete_run();
    end

    initial begin
        n_errors    = 0;
        num_checks  = 0;
        sys_rst     = 1'b1;
        req_valid   = 1'b0;
        req_write   = 1'b0;
        req_addr    = 7'h00;
        req_wdata   = 8'h00;
        shut_req    = 1'b0;
        motion_data = 8'hA5;
        link2.sclk  = 1'b1;
        link2.mosi  = 1'b1;
        link2.ncs_n = 1'b1;
        link2.shutdown = 1'b0;
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        @(negedge clock);
        check8({link.sclk, link.mosi, link.ncs_n, link.shutdown, link.miso, 3'h0}, 8'hE8, "idle link");
        wait_high(motion_valid, MRL + 5, cnt);
        xfer(1'b0, ADDR_MOTION, 8'h00, rd);
        check8(rd, 8'hA5, "motion read");
        xfer(1'b0, 7'h7F, 8'h00, rd);
        check8(rd, 8'h00, "unmapped read");
        xfer(1'b1, ADDR_REST, 8'h03, rd);
        wait_high(low_current, 10, cnt);
        xfer(1'b1, ADDR_REST, 8'h02, rd);
        xfer(1'b0, ADDR_REST, 8'h00, rd);
        check8(rd, 8'h02, "rest readback");
        xfer(1'b0, ADDR_STATUS, 8'h00, rd);
        check8(rd, 8'h02, "status in rest");
        xfer(1'b1, ADDR_REST, 8'h00, rd);
        wait_high(motion_valid, 10, cnt);
        xfer(1'b0, ADDR_STATUS, 8'h00, rd);
        check8(rd, 8'h01, "status running");
        // shutdown, then the host must reinitialise on its own
        @(posedge clock);
        shut_req <= 1'b1;
        wait_high(low_current, 10, cnt);
        check8({6'h00, req_ready, motion_valid}, 8'h00, "refused in shutdown");
        repeat (300) @(posedge clock);
        shut_req <= 1'b0;
        wait_high(motion_valid, WKL + MRL + 1500, cnt);
        check8({7'h00, cnt >= WKL}, 8'h01, "early motion after wake");
        // second link: abort mid address, then a full write must still align
        @(posedge clock);
        link2.ncs_n <= 1'b0;
        repeat (5) @(posedge clock);
        bang(8'hA5, 4, rd);
        link2.ncs_n <= 1'b1;
        repeat (25) @(posedge clock);
        link2.ncs_n <= 1'b0;
        repeat (5) @(posedge clock);
        bang({DIR_WRITE, ADDR_REST}, 8, rd);
        bang(8'h01, 8, rd);
        repeat (625) @(posedge clock);
        link2.ncs_n <= 1'b1;
        repeat (50) @(posedge clock);
        check8({6'h00, low_current2, motion_valid2}, 8'h02, "write after abort");
        link2.ncs_n <= 1'b0;
        repeat (5) @(posedge clock);
        bang({1'b0, ADDR_STATUS}, 8, rd);
        repeat (125) @(posedge clock);
        bang(8'h00, 8, rd);
        repeat (5) @(posedge clock);
        link2.ncs_n <= 1'b1;
        check8(rd, 8'h02, "wire read of status");
        repeat (12) @(posedge clock);
        check8({6'h00, link2.miso, link2.miso_oe}, 8'h02, "data out released");
        complete_run();
    end
endmodule
